// ===== hdl/sscs_pkg.sv
package sscs_pkg;
  // register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] REG_CTRL = 8'h00; // mode and start
  localparam logic [7:0] REG_REF = 8'h04; // ref_divider and prescaler choice
  localparam logic [7:0] REG_CHAN = 8'h08; // division count of the wanted channel
  localparam logic [7:0] REG_STAT = 8'h0C; // status
  // control fields
  localparam int CTRL_START = 0; // write 1: program the channel
  localparam int CTRL_TX = 1; // 1 = transmit, 0 = receive
  localparam int CTRL_ENABLE = 2; // 0 = both selects released high
  localparam int REF_PRESC = 14; // 0 = prescaler 64, 1 = 128
  // status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_LOCK = 1;
  localparam int STAT_READY = 2;
  localparam int STAT_LOCK_FAIL = 3;
  localparam int STAT_REFUSED = 4;
  localparam int STAT_FIRST_DONE = 5;
  // field widths
  localparam int MAIN_W = 11;
  localparam int SWAL_W = 7;
  localparam int REFD_W = 14;
  localparam int WORD_W = 19;
  // operation bits at the head of the reference word
  localparam logic OP_CHARGE_PUMP = 1'b0;
  localparam logic OP_LOCK_OUT = 1'b0;
  localparam logic OP_PHASE_POL = 1'b1;
  // latch select values (last bit shifted)
  localparam logic SEL_REF = 1'b1;
  localparam logic SEL_DIV = 1'b0;
  // limits
  localparam int MAIN_MIN = 3;
  localparam int REFD_MIN = 3;
  // reset values
  localparam logic [REFD_W:0] REF_RESET = 15'h06A4; // 1700, prescaler 64
  localparam logic [31:0] CHAN_RESET = 32'h0000_8858; // 34904
  // timing
  localparam int CLK_MHZ = 100;
  localparam int BIT_HALF_US = 100; // half period of the serial clock
  localparam int BIT_HALF_CYC = BIT_HALF_US * CLK_MHZ;
  localparam int LOCK_CHECK_MS = 20;
  localparam int SETTLE_FIRST_MS = 40;
  localparam int SETTLE_LATER_MS = 20;
  localparam int LOCK_CHECK_CYC = LOCK_CHECK_MS * 1000 * CLK_MHZ;
  localparam int SETTLE_FIRST_CYC = SETTLE_FIRST_MS * 1000 * CLK_MHZ;
  localparam int SETTLE_LATER_CYC = SETTLE_LATER_MS * 1000 * CLK_MHZ;
endpackage

// ===== hdl/sscs_host.sv
// Function
// - transmit: tx select low, rx select high
// - receive: rx select low, tx select high
// - data pulses between 100 us and 15 ms
// - prescaler is 64 or 128
// - main divider 11 bits, 3 to 2047
// - swallow divider 7 bits, 0 to 127
// - reference divider 14 bits, 3 to 16383
// - compare frequency 6.25, 12.5 or 25 kHz
// - main is quotient, swallow is remainder
// - charge pump bit always sent 0
// - lock output select bit always 0
// - phase polarity bit always 1
// - operation bits head the reference word
// - latch select bit is shifted last
// - the two words go in either order
// - vco target is channel minus offset
// - ref divider is reference over compare
// - channel change sends that channel's settings
// - reprogram only in receive mode; a start with enable clear is also accepted
// - check lock high 20 ms after change
// - wait 40 ms first, 20 ms later
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// overview
// software writes the reference word value and the division count, then
// sets start with transmit clear; the block splits the count by the
// prescaler, shifts the reference word and then the divider word msb first,
// pulses the load strobe after each, and waits for the vco to settle.
// register map, one aligned word each:
//   0x00 control: bit 0 start (self clearing), bit 1 transmit, bit 2 enable
//   0x04 reference: bits 13:0 reference divider, bit 14 prescaler 128
//   0x08 channel: division count of the wanted channel
//   0x0C status: busy, lock, ready, lock fail, refused, first done
// the count and reference divider are computed by software from the channel table, so this
// block only splits and range-checks them; a bad count is refused, never wrapped.
// serial timing: data moves while the shift clock is low and stands for
// two half periods, 200 us at the default count, well inside the limits
// on pulse width; a slower clock only costs programming time.
// the block cannot see whether the radio was power cycled, so software
// must pulse reset after powering it, to get the longer first settle.
module sscs_host #(
  parameter int HALF_CYC = sscs_pkg::BIT_HALF_CYC,
  parameter int LOCK_CYC = sscs_pkg::LOCK_CHECK_CYC,
  parameter int FIRST_CYC = sscs_pkg::SETTLE_FIRST_CYC,
  parameter int LATER_CYC = sscs_pkg::SETTLE_LATER_CYC
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // synthesizer serial lines
  output logic syn_clk,
  output logic syn_data,
  output logic latch_load_strobe,
  input wire logic lock_detect,
  // mode selects
  output logic tx_select_n,
  output logic rx_select_n
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  initial begin
    if (HALF_CYC < 1 || LOCK_CYC < 1 || FIRST_CYC < 1 || LATER_CYC < 1) begin
      $error("sscs_host: timing counts must be at least one cycle");
    end
    // the lock check counts down inside the settle wait, so it must fit there
    if (LOCK_CYC > FIRST_CYC || LOCK_CYC > LATER_CYC) begin
      $error("sscs_host: lock check must not be later than the settle time");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // types and declarations
  // the sequencer walks low, high per bit, then load and gap per word
  typedef enum logic [2:0] {
    SSCS_IDLE, SSCS_LOW, SSCS_HIGH, SSCS_LOAD, SSCS_GAP, SSCS_SETTLE
  } sscs_state_t;

  sscs_state_t state_reg; // sequencer state
  logic [sscs_pkg::REFD_W:0] ref_reg; // prescaler choice and ref divider
  logic [31:0] chan_reg; // division count
  logic tx_reg; // transmit requested
  logic en_reg; // selects active at all
  logic [sscs_pkg::WORD_W-1:0] shift_reg; // word being sent, msb first
  logic [4:0] bit_reg; // bits left in word
  logic word_reg; // 0 = reference word, 1 = divider word
  logic [31:0] cnt_reg; // shared timer
  logic lock_s1_reg; // synchroniser stage one
  logic lock_s2_reg; // synchronised lock
  logic first_done_reg; // first channel since reset done
  logic lock_fail_reg; // lock not seen at check
  logic refused_reg; // start refused (tx, bad value or busy)
  logic ready_reg; // settle time elapsed
  logic checked_reg; // lock check already made this change
  logic start_w; // start write strobe
  logic wr_w; // apb write access
  logic [sscs_pkg::MAIN_W-1:0] main_w; // computed main divider
  logic [sscs_pkg::SWAL_W-1:0] swal_w; // computed swallow divider
  logic values_ok_w; // dividers inside their ranges
  logic [sscs_pkg::WORD_W-1:0] ref_word_w; // reference word
  logic [sscs_pkg::WORD_W-1:0] div_word_w; // divider word

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, unmapped reads give zero, no error
  // read data is fetched at setup, so the access phase never needs to wait
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_w = psel && penable && pwrite && clk_en;
  assign start_w = wr_w && paddr == sscs_pkg::REG_CTRL && pwdata[sscs_pkg::CTRL_START];

  // control registers; a write while frozen by clk_en is lost, not delayed
  // the start bit is not stored, it only acts in the cycle of its write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_reg <= sscs_pkg::REF_RESET;
      chan_reg <= sscs_pkg::CHAN_RESET;
      tx_reg <= 1'b0;
      en_reg <= 1'b0;
    end else if (wr_w) begin
      unique case (paddr)
        sscs_pkg::REG_CTRL: begin
          tx_reg <= pwdata[sscs_pkg::CTRL_TX];
          en_reg <= pwdata[sscs_pkg::CTRL_ENABLE];
        end
        // software derives the reference divider from the compare frequency
        sscs_pkg::REG_REF: ref_reg <= pwdata[sscs_pkg::REFD_W:0];
        // count of the vco target, channel minus the offset, from the table
        sscs_pkg::REG_CHAN: chan_reg <= pwdata;
        default: begin
          // writes elsewhere are ignored
        end
      endcase
    end
  end

  // read data comes from a flip-flop, loaded during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      unique case (paddr)
        sscs_pkg::REG_CTRL: prdata <= {29'h0000_0000, en_reg, tx_reg, 1'b0};
        sscs_pkg::REG_REF: prdata <= {17'h0_0000, ref_reg};
        sscs_pkg::REG_CHAN: prdata <= chan_reg;
        sscs_pkg::REG_STAT: prdata <= {26'h000_0000, first_done_reg, refused_reg,
          lock_fail_reg, ready_reg, lock_s2_reg, state_reg != SSCS_IDLE};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // divider arithmetic and word assembly
  // prescaler 64 or 128 makes the split a plain bit select, no divider needed
  always_comb begin
    // quotient and remainder by the chosen prescaler
    if (ref_reg[sscs_pkg::REF_PRESC]) begin
      main_w = chan_reg[sscs_pkg::MAIN_W+6:7];
      swal_w = chan_reg[6:0];
    end else begin
      main_w = chan_reg[sscs_pkg::MAIN_W+5:6];
      swal_w = {1'b0, chan_reg[5:0]};
    end
  end
  // counts too big for the 11-bit main divider are refused rather than wrapped
  assign values_ok_w = (ref_reg[sscs_pkg::REF_PRESC] ? chan_reg[31:18] == 14'h0000
      : chan_reg[31:17] == 15'h0000)
    && main_w >= sscs_pkg::MAIN_W'(sscs_pkg::MAIN_MIN)
    && ref_reg[sscs_pkg::REFD_W-1:0] >= sscs_pkg::REFD_W'(sscs_pkg::REFD_MIN);
  // op bits first, then ref divider, select bit last
  assign ref_word_w = {sscs_pkg::OP_CHARGE_PUMP, sscs_pkg::OP_LOCK_OUT,
    sscs_pkg::OP_PHASE_POL, ref_reg[sscs_pkg::REFD_W-1:0],
    ref_reg[sscs_pkg::REF_PRESC], sscs_pkg::SEL_REF};
  assign div_word_w = {main_w, swal_w, sscs_pkg::SEL_DIV};

  ////////////////////////////////////////////////////////////////////////////
  // lock detect synchroniser; the pin is asynchronous to pclk and may chatter
  // while the loop pulls in, so only the second stage is ever read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_s1_reg <= 1'b0;
      lock_s2_reg <= 1'b0;
    end else if (clk_en) begin
      lock_s1_reg <= lock_detect;
      lock_s2_reg <= lock_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial sequencer: reference word then divider word, then settle
  // one shared timer paces half periods, the strobe, the gap and the settle wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SSCS_IDLE;
      shift_reg <= '0;
      bit_reg <= 5'h00;
      word_reg <= 1'b0;
      cnt_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      unique case (state_reg)
        SSCS_IDLE: begin
          // a start in transmit mode is refused to avoid stray emission; the mode
          // written with the start counts, since it takes effect at the same edge
          if (start_w && !pwdata[sscs_pkg::CTRL_TX] && values_ok_w) begin
            shift_reg <= ref_word_w;
            bit_reg <= 5'(sscs_pkg::WORD_W);
            word_reg <= 1'b0;
            cnt_reg <= 32'(HALF_CYC - 1);
            state_reg <= SSCS_LOW;
          end
        end
        SSCS_LOW: begin
          // data set up while the clock is low
          if (cnt_reg == 32'h0000_0000) begin
            cnt_reg <= 32'(HALF_CYC - 1);
            state_reg <= SSCS_HIGH;
          end else begin
            cnt_reg <= cnt_reg - 32'h0000_0001;
          end
        end
        SSCS_HIGH: begin
          if (cnt_reg == 32'h0000_0000) begin
            cnt_reg <= 32'(HALF_CYC - 1);
            shift_reg <= {shift_reg[sscs_pkg::WORD_W-2:0], 1'b0};
            bit_reg <= bit_reg - 5'h01;
            state_reg <= (bit_reg == 5'h01) ? SSCS_LOAD : SSCS_LOW;
          end else begin
            cnt_reg <= cnt_reg - 32'h0000_0001;
          end
        end
        SSCS_LOAD: begin
          // strobe high for one half period, rising as the last clock falls
          if (cnt_reg == 32'h0000_0000) begin
            cnt_reg <= 32'(HALF_CYC - 1);
            state_reg <= SSCS_GAP;
          end else begin
            cnt_reg <= cnt_reg - 32'h0000_0001;
          end
        end
        SSCS_GAP: begin
          // gap with all lines low before the next word or the settle wait
          if (cnt_reg != 32'h0000_0000) begin
            cnt_reg <= cnt_reg - 32'h0000_0001;
          end else if (!word_reg) begin
            shift_reg <= div_word_w;
            bit_reg <= 5'(sscs_pkg::WORD_W);
            word_reg <= 1'b1;
            cnt_reg <= 32'(HALF_CYC - 1);
            state_reg <= SSCS_LOW;
          end else begin
            // first change waits longer while the vco settles
            cnt_reg <= first_done_reg ? 32'(LATER_CYC - 1) : 32'(FIRST_CYC - 1);
            state_reg <= SSCS_SETTLE;
          end
        end
        SSCS_SETTLE: begin
          if (cnt_reg == 32'h0000_0000) begin
            state_reg <= SSCS_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 32'h0000_0001;
          end
        end
        default: state_reg <= SSCS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_done_reg <= 1'b0;
      lock_fail_reg <= 1'b0;
      refused_reg <= 1'b0;
      ready_reg <= 1'b0;
      checked_reg <= 1'b0;
    end else if (clk_en) begin
      if (start_w) begin
        // an accepted start clears old results; a refusal sets its flag at once
        // judged on the mode written together with the start, as the sequencer does
        refused_reg <= pwdata[sscs_pkg::CTRL_TX] || !values_ok_w ||
          state_reg != SSCS_IDLE;
        if (!pwdata[sscs_pkg::CTRL_TX] && values_ok_w && state_reg == SSCS_IDLE) begin
          ready_reg <= 1'b0;
          lock_fail_reg <= 1'b0;
          checked_reg <= 1'b0;
        end
      end
      // lock checked once, lock-check time after the change
      // both checks share checked_reg, so a chattering lock is never judged twice
      if (state_reg == SSCS_SETTLE && !checked_reg &&
          cnt_reg == 32'(FIRST_CYC - LOCK_CYC) && !first_done_reg) begin
        checked_reg <= 1'b1;
        lock_fail_reg <= !lock_s2_reg;
      end
      if (state_reg == SSCS_SETTLE && !checked_reg &&
          cnt_reg == 32'(LATER_CYC - LOCK_CYC) && first_done_reg) begin
        checked_reg <= 1'b1;
        lock_fail_reg <= !lock_s2_reg;
      end
      if (state_reg == SSCS_SETTLE && cnt_reg == 32'h0000_0000) begin
        ready_reg <= 1'b1;
        first_done_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin outputs, all from flip-flops
  // registered so that the pins never glitch while the state changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      syn_clk <= 1'b0;
      syn_data <= 1'b0;
      latch_load_strobe <= 1'b0;
      tx_select_n <= 1'b1;
      rx_select_n <= 1'b1;
    end else if (clk_en) begin
      syn_clk <= state_reg == SSCS_HIGH;
      // each bit stands two half periods on the data line
      syn_data <= shift_reg[sscs_pkg::WORD_W-1];
      latch_load_strobe <= state_reg == SSCS_LOAD;
      // transmit only when idle; never both selects low
      tx_select_n <= !(en_reg && tx_reg && state_reg == SSCS_IDLE);
      rx_select_n <= !(en_reg && !(tx_reg && state_reg == SSCS_IDLE));
    end
  end

endmodule
`default_nettype wire

// ===== test/sscs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sscs_properties #(
  parameter int HALF_CYC = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial lines and selects
  input wire logic syn_clk,
  input wire logic syn_data,
  input wire logic latch_load_strobe,
  input wire logic tx_select_n,
  input wire logic rx_select_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  // helper counters: lengths of high phases and clock rises per word
  logic clk_q;
  logic [15:0] hi_cnt;
  logic [15:0] st_cnt;
  logic [7:0] bit_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_q <= 1'b0;
      hi_cnt <= 16'h0000;
      st_cnt <= 16'h0000;
      bit_cnt <= 8'h00;
    end else begin
      clk_q <= syn_clk;
      hi_cnt <= syn_clk ? hi_cnt + 16'h0001 : 16'h0000;
      st_cnt <= latch_load_strobe ? st_cnt + 16'h0001 : 16'h0000;
      // a strobe closes the word, so the count restarts there
      if (latch_load_strobe) begin
        bit_cnt <= 8'h00;
      end else if (syn_clk && !clk_q) begin
        bit_cnt <= bit_cnt + 8'h01;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_tx_rx_excl: assert property (!tx_select_n |-> rx_select_n)
    else $error("rx select low while tx select low");
  a_rx_tx_excl: assert property (!rx_select_n |-> tx_select_n)
    else $error("tx select low while rx select low");
  a_data_steady: assert property (syn_clk |-> $stable(syn_data))
    else $error("serial data moved while shift clock high");
  a_clk_high_len: assert property ($fell(syn_clk) |-> hi_cnt == HALF_CYC)
    else $error("shift clock high phase has wrong length");
  a_strobe_len: assert property ($fell(latch_load_strobe) |-> st_cnt == HALF_CYC)
    else $error("load strobe has wrong length");
  a_strobe_clk_low: assert property (latch_load_strobe |-> !syn_clk)
    else $error("shift clock high during load strobe");
  a_word_bits: assert property ($rose(latch_load_strobe) |-> bit_cnt == sscs_pkg::WORD_W)
    else $error("word length at strobe is wrong");
  a_strobe_gap: assert property ($fell(latch_load_strobe) |-> !syn_clk [*2])
    else $error("shift clock restarted right after strobe");
  a_no_prog_tx: assert property (!tx_select_n |-> !syn_clk && !latch_load_strobe)
    else $error("programming while transmit selected");
  c_load: cover property ($rose(latch_load_strobe));
  c_tx: cover property ($fell(tx_select_n));
  c_rx: cover property ($fell(rx_select_n));
endmodule
bind sscs_host sscs_properties #(.HALF_CYC(HALF_CYC)) i_sscs_properties (.pclk(pclk),
  .presetn(presetn), .syn_clk(syn_clk), .syn_data(syn_data),
  .latch_load_strobe(latch_load_strobe), .tx_select_n(tx_select_n), .rx_select_n(rx_select_n));
`default_nettype wire

// ===== test/sscs_synth_model.sv
`timescale 1ns/1ps
`default_nettype none
module sscs_synth_model (
  // serial lines from the host
  input wire logic syn_clk,
  input wire logic syn_data,
  input wire logic latch_load_strobe,
  // lock state chosen by the bench
  input wire logic lock_ok,
  output logic lock_detect,
  // latched words and count of loads
  output logic [18:0] ref_latch,
  output logic [18:0] div_latch,
  output logic [7:0] loads
);
  logic [18:0] shift_reg; // no reset pin, so it starts cleared
  initial begin
    shift_reg = 19'h00000;
    ref_latch = 19'h00000;
    div_latch = 19'h00000;
    loads = 8'h00;
  end
  // one bit per rising shift clock, newest at the bottom
  always @(posedge syn_clk) begin
    shift_reg <= {shift_reg[17:0], syn_data};
  end
  // the last bit in picks the latch
  always @(posedge latch_load_strobe) begin
    loads <= loads + 8'h01;
    if (shift_reg[0] == sscs_pkg::SEL_REF) begin
      ref_latch <= shift_reg;
    end else begin
      div_latch <= shift_reg;
    end
  end
  assign lock_detect = lock_ok;
endmodule
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // bench drive and design outputs
  logic pclk, presetn, clk_en, psel, penable, pwrite, lock_ok;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, syn_clk, syn_data, latch_load_strobe, lock_detect;
  logic tx_select_n, rx_select_n;
  logic [18:0] ref_latch, div_latch;
  logic [7:0] loads;
  int err_count, n_compared;
  sscs_host #(.HALF_CYC(2), .LOCK_CYC(20), .FIRST_CYC(40), .LATER_CYC(20)) i_sscs_host (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .syn_clk(syn_clk), .syn_data(syn_data),
    .latch_load_strobe(latch_load_strobe), .lock_detect(lock_detect),
    .tx_select_n(tx_select_n), .rx_select_n(rx_select_n));
  sscs_synth_model i_sscs_synth_model (.syn_clk(syn_clk), .syn_data(syn_data),
    .latch_load_strobe(latch_load_strobe), .lock_ok(lock_ok), .lock_detect(lock_detect),
    .ref_latch(ref_latch), .div_latch(div_latch), .loads(loads));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready is seen with penable
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // start a channel and poll status until settled, bounded
  task run_case(input logic [31:0] refv, chan, input logic [18:0] er, ed, input logic lk);
    lock_ok <= lk;
    apb(1'b1, sscs_pkg::REG_REF, refv);
    apb(1'b1, sscs_pkg::REG_CHAN, chan);
    apb(1'b1, sscs_pkg::REG_CTRL, 32'h0000_0005);
    for (int i = 0; i < 200; i++) begin
      apb(1'b0, sscs_pkg::REG_STAT, 32'h0);
      if (rd[0] === 1'b0 && rd[2] === 1'b1) break;
    end
    check("ref word", 32'(ref_latch), 32'(er));
    check("div word", 32'(div_latch), 32'(ed));
    check("lock fail", 32'(rd[3]), 32'(!lk));
    check("lock", 32'(rd[1]), 32'(lk));
    check("first done", 32'(rd[5]), 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task test_reset;
    check("selects", {30'h0, tx_select_n, rx_select_n}, 32'h3);
    // a write while the clock enable is low must be lost
    clk_en <= 1'b0;
    apb(1'b1, sscs_pkg::REG_REF, 32'h0000_1234);
    clk_en <= 1'b1;
    apb(1'b0, sscs_pkg::REG_REF, 32'h0);
    check("ref reset", rd, 32'h0000_06A4);
    check("bus answer", {30'h0, pready, pslverr}, 32'h2);
    apb(1'b0, sscs_pkg::REG_CHAN, 32'h0);
    check("chan reset", rd, 32'h0000_8858);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped", rd, 32'h0);
  endtask
  task test_channels;
    run_case(32'h06A4, 32'h8858, {3'h1, 14'h06A4, 2'h1}, {11'h221, 7'h18, 1'h0}, 1'b1);
    run_case(32'h0003, 32'h00C0, {3'h1, 14'h0003, 2'h1}, {11'h003, 7'h00, 1'h0}, 1'b1);
    run_case(32'h4352, 32'h967F, {3'h1, 14'h0352, 2'h3}, {11'h12C, 7'h7F, 1'h0}, 1'b0);
    check("loads", 32'(loads), 32'h6);
    lock_ok <= 1'b1;
  endtask
  task test_refused;
    // reference divider too small, then main divider too small, then too large
    apb(1'b1, sscs_pkg::REG_REF, 32'h2);
    apb(1'b1, sscs_pkg::REG_CTRL, 32'h5);
    apb(1'b0, sscs_pkg::REG_STAT, 32'h0);
    check("refused ref", 32'(rd[4]), 32'h1);
    apb(1'b1, sscs_pkg::REG_REF, 32'h06A4);
    apb(1'b1, sscs_pkg::REG_CHAN, 32'h85);
    apb(1'b1, sscs_pkg::REG_CTRL, 32'h5);
    apb(1'b0, sscs_pkg::REG_STAT, 32'h0);
    check("refused low", 32'(rd[4]), 32'h1);
    apb(1'b1, sscs_pkg::REG_CHAN, 32'h20000);
    apb(1'b1, sscs_pkg::REG_CTRL, 32'h5);
    apb(1'b0, sscs_pkg::REG_STAT, 32'h0);
    check("refused high", 32'(rd[4]), 32'h1);
    apb(1'b1, sscs_pkg::REG_CHAN, 32'h8858);
    apb(1'b1, sscs_pkg::REG_CTRL, 32'h7);
    repeat (100) @(posedge pclk);
    apb(1'b0, sscs_pkg::REG_STAT, 32'h0);
    check("refused", 32'(rd[4]), 32'h1);
    check("no load", 32'(loads), 32'h6);
    check("tx mode", {30'h0, tx_select_n, rx_select_n}, 32'h1);
    apb(1'b1, sscs_pkg::REG_CTRL, 32'h4);
    repeat (3) @(posedge pclk);
    check("rx mode", {30'h0, tx_select_n, rx_select_n}, 32'h2);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    {psel, penable, pwrite, lock_ok} = 4'h1;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    n_compared = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    test_reset;
    test_channels;
    test_refused;
    give_verdict;
  end
  // a hang ends the run as a failure
  initial begin
    #500000;
    err_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
